// [verilog/frs_supervisor.sv]
`timescale 1ns/1ps
module frs_supervisor
  import frs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned RESTART_TICKS = RESTART_DELAY_TICKS,
  parameter int unsigned MIN_OFF_T = MIN_OFF_TICKS,
  parameter int unsigned WINDOW_T = WINDOW_TICKS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_prog_connected,
  input wire logic [11:0] i_prog_cv,
  input wire logic i_remote_on,
  input wire logic i_present_n,
  input wire logic i_ac_ok,
  input wire logic i_overvoltage_protect,
  input wire logic i_overcurrent_protect,
  input wire logic i_overtemp,
  input wire logic i_no_output,
  output logic o_main_enable,
  output logic [11:0] o_setpoint_cv,
  output logic o_prog_active,
  output logic o_fault_n,
  output logic o_latched_off
);
  import frs_pkg::*;

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  frs_state_t state;
  frs_state_t next_state;
  logic op_on;
  logic op_on_d;
  logic latch_mode;
  logic [15:0] vout_cmd;
  logic [ALARM_W-1:0] alarm;
  logic [1:0] ov_count;
  logic window_run;
  logic remote_d;
  logic power_ok;
  logic power_ok_d;
  logic hw_fault;
  logic user_off;
  logic clear_latch;
  logic restart_ok;
  logic load_delay;
  logic delay_done;
  logic load_win;
  logic win_done;
  logic [16:0] delay_ticks;

  assign hw_fault = i_overcurrent_protect || i_overtemp;
  // a pulled board or lost mains both count as a power removal
  assign power_ok = !i_present_n && i_ac_ok;
  assign user_off = !i_remote_on || !op_on || !power_ok;

  // off then on of any source, seen as a rising edge of that source on its own
  assign clear_latch = (i_remote_on && !remote_d)
                    || (op_on && !op_on_d)
                    || (power_ok && !power_ok_d);

  // ----------------------------------------
  // timers
  // ----------------------------------------
  frs_timer #(.TICK_CYCLES(TICK_CYCLES_P), .W(17)) u_delay (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(load_delay),
    .i_ticks(delay_ticks),
    .o_done(delay_done)
  );

  frs_timer #(.TICK_CYCLES(TICK_CYCLES_P), .W(17)) u_window (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(load_win),
    .i_ticks(17'(WINDOW_T)),
    .o_done(win_done)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    load_delay = 1'b0;
    delay_ticks = 17'(MIN_OFF_T);
    restart_ok = 1'b0;
    case (state)
      FRS_ON: begin
        if (user_off) begin
          next_state = FRS_OFF_USER;
          load_delay = 1'b1;
        end else if (i_overvoltage_protect) begin
          next_state = FRS_OFF_OV;
          load_delay = 1'b1;
          delay_ticks = 17'(RESTART_TICKS);
          if (ov_count == 2'(OV_LIMIT - 1)) begin
            next_state = latch_mode ? FRS_LATCHED : FRS_OFF_OV;
          end
        end else if (hw_fault) begin
          next_state = FRS_OFF_FAULT;
        end
      end
      FRS_OFF_FAULT: begin
        // the enable sources still rule while waiting for the fault to clear
        if (user_off) begin
          next_state = FRS_OFF_USER;
          load_delay = 1'b1;
        end else if (!hw_fault) begin
          next_state = FRS_ON;
          restart_ok = 1'b1;
        end
      end
      FRS_OFF_OV: begin
        // a fault that arrives during the wait holds the output off until it clears
        if (user_off) begin
          next_state = FRS_OFF_USER;
          load_delay = 1'b1;
        end else if (delay_done && !i_overvoltage_protect && !hw_fault) begin
          next_state = FRS_ON;
        end
      end
      FRS_LATCHED: begin
        // the mode change skips the off time but never overrides an off request or a fault
        if (!latch_mode && !user_off && !hw_fault) begin
          next_state = FRS_ON;
          restart_ok = 1'b1;
        end else if (!latch_mode || clear_latch) begin
          // timing from the release keeps even a short off pulse at the full minimum
          next_state = FRS_OFF_USER;
          load_delay = 1'b1;
        end
      end
      FRS_OFF_USER: begin
        if (user_off) begin
          load_delay = 1'b1;
        end else if (delay_done && !hw_fault) begin
          next_state = FRS_ON;
          restart_ok = 1'b1;
        end
      end
      default: begin
        next_state = FRS_OFF_USER;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= FRS_OFF_USER;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // overvoltage window
  // ----------------------------------------
  // window opens on the first trip with none running; count saturates at the limit
  // in auto-restart mode the count still saturates, so status keeps showing repeated trips
  assign load_win = (state == FRS_ON) && i_overvoltage_protect && !window_run;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ov_count <= 2'h0;
      window_run <= 1'b0;
    end else if (next_state == FRS_LATCHED || state == FRS_LATCHED) begin
      ov_count <= 2'h0;
      window_run <= 1'b0;
    end else if (load_win) begin
      ov_count <= 2'h1;
      window_run <= 1'b1;
    end else if ((state == FRS_ON) && i_overvoltage_protect) begin
      if (ov_count != 2'(OV_LIMIT)) begin
        ov_count <= ov_count + 2'h1;
      end
    end else if (window_run && win_done) begin
      ov_count <= 2'h0;
      window_run <= 1'b0;
    end
  end

  // ----------------------------------------
  // edge history
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // idle-on history, so a source held on through reset is not taken for a release
      remote_d <= 1'b1;
      op_on_d <= 1'b1;
      power_ok_d <= 1'b1;
    end else begin
      remote_d <= i_remote_on;
      op_on_d <= op_on;
      power_ok_d <= power_ok;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      op_on <= OPERATION_RST[0];
      vout_cmd <= VOUT_CMD_RST;
      latch_mode <= 1'b1;
    end else if (i_wr) begin
      case (i_addr)
        REG_OPERATION: op_on <= i_wdata[0];
        REG_VOUT_CMD: vout_cmd <= i_wdata;
        // upper bits of these two words are not kept and read back as zero
        REG_OV_MODE: latch_mode <= i_wdata[0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // alarm records
  // ----------------------------------------
  // a new event in the restart cycle wins over the clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      alarm <= '0;
    end else begin
      alarm <= (restart_ok ? '0 : alarm)
             | {i_no_output, !i_ac_ok, i_overcurrent_protect, i_overvoltage_protect, i_overtemp};
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_main_enable <= 1'b0;
      o_setpoint_cv <= NOMINAL_CV;
      o_prog_active <= 1'b0;
      o_fault_n <= 1'b1;
      o_latched_off <= 1'b0;
    end else begin
      // taken from the next state so the output reacts one edge after the cause, not two
      o_main_enable <= (next_state == FRS_ON);
      if (i_prog_connected && i_prog_cv <= PROG_LIMIT_CV) begin
        o_setpoint_cv <= i_prog_cv;
        o_prog_active <= 1'b1;
      end else begin
        o_setpoint_cv <= vout_cmd[11:0];
        o_prog_active <= 1'b0;
      end
      o_fault_n <= !(i_overtemp || i_overvoltage_protect || i_overcurrent_protect
                     || !i_ac_ok || i_no_output);
      o_latched_off <= (next_state == FRS_LATCHED);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        REG_OPERATION: o_rdata <= {15'h0000, op_on};
        REG_VOUT_CMD: o_rdata <= vout_cmd;
        REG_OV_MODE: o_rdata <= {15'h0000, latch_mode};
        REG_STATUS: o_rdata <= {10'h000, window_run, ov_count, state};
        REG_ALARM: o_rdata <= {11'h000, alarm};
        REG_SETPOINT: o_rdata <= {4'h0, o_setpoint_cv};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      // idle at zero so a late sample never sees stale status
      o_rdata <= 16'h0000;
    end
  end
endmodule

// [verilog/frs_pkg.sv]
package frs_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned RESTART_DELAY_MS = 1000;
  localparam int unsigned MIN_OFF_MS = 2000;
  localparam int unsigned WINDOW_MS = 60000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
  localparam int unsigned RESTART_DELAY_TICKS = RESTART_DELAY_MS * 1000 / TICK_US;
  localparam int unsigned MIN_OFF_TICKS = MIN_OFF_MS * 1000 / TICK_US;
  localparam int unsigned WINDOW_TICKS = WINDOW_MS * 1000 / TICK_US;
  localparam int unsigned OV_LIMIT = 3;

  // ----------------------------------------
  // setpoint selection (units of 10 mV)
  // ----------------------------------------
  localparam logic [11:0] PROG_LIMIT_CV = 12'h12C;
  localparam logic [11:0] NOMINAL_CV = 12'h4B0;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] REG_OPERATION = 4'h1;
  localparam logic [3:0] REG_VOUT_CMD = 4'h2;
  localparam logic [3:0] REG_OV_MODE = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ALARM = 4'h5;
  localparam logic [3:0] REG_SETPOINT = 4'h6;
  localparam logic [15:0] OPERATION_RST = 16'h0001;
  localparam logic [15:0] VOUT_CMD_RST = 16'h04B0;
  localparam int unsigned ALARM_OT = 0;
  localparam int unsigned ALARM_OV = 1;
  localparam int unsigned ALARM_OC = 2;
  localparam int unsigned ALARM_IN = 3;
  localparam int unsigned ALARM_NOOUT = 4;
  localparam int unsigned ALARM_W = 5;

  typedef enum logic [2:0] {
    FRS_ON = 3'b000,
    FRS_OFF_FAULT = 3'b001,
    FRS_OFF_OV = 3'b010,
    FRS_LATCHED = 3'b011,
    FRS_OFF_USER = 3'b100
  } frs_state_t;
endpackage

// [verilog/frs_timer.sv]
`timescale 1ns/1ps
// down counter of prescaled ticks; free-running prescaler so timing is coarse by one tick
module frs_timer #(
  parameter int unsigned TICK_CYCLES = 25000,
  parameter int unsigned W = 17
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_ticks,
  output logic o_done
);
  logic [15:0] pre;
  logic [W-1:0] count;
  logic tick;

  assign tick = (pre == 16'(TICK_CYCLES - 1));

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pre <= 16'h0000;
    end else if (tick) begin
      pre <= 16'h0000;
    end else begin
      pre <= pre + 16'h0001;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count <= '0;
    end else if (i_load) begin
      count <= i_ticks;
    end else if (tick && count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign o_done = (count == '0) && !i_load;
endmodule

// [tb/frs_stage_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// output stage that overshoots on demand
// ----------------------------------------
module frs_stage_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_main_enable,
  input wire logic i_ov_fail,
  output logic o_overvoltage_protect
);
  logic [2:0] age;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) age <= 3'h0;
    else if (!i_main_enable) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  // trips two cycles into every turn-on, so each restart attempt fails
  assign o_overvoltage_protect = i_ov_fail && i_main_enable && (age >= 3'h2);
endmodule

// [tb/frs_supervisor_assertions.sv]
`timescale 1ns/1ps
module frs_supervisor_chk
  import frs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = 10,
  parameter int unsigned RESTART_TICKS = 5,
  parameter int unsigned MIN_OFF_T = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic [11:0] i_prog_cv,
  input wire logic i_prog_connected,
  input wire logic i_remote_on,
  input wire logic i_overvoltage_protect,
  input wire logic i_overcurrent_protect,
  input wire logic i_overtemp,
  input wire logic i_no_output,
  input wire logic o_main_enable,
  input wire logic [11:0] o_setpoint_cv,
  input wire logic o_prog_active,
  input wire logic o_fault_n,
  input wire logic o_latched_off
);
  localparam int unsigned OFF_MIN = (MIN_OFF_T - 1) * TICK_CYCLES_P;
  localparam int unsigned OV_MIN = (RESTART_TICKS - 1) * TICK_CYCLES_P;
  logic [15:0] off_cnt;
  logic [15:0] ov_cnt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // cycles since pin off and since overvoltage
  // ----------------------------------------
  // start saturated so the first turn-on after reset is not taken for a restart
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) off_cnt <= 16'hFFFF;
    else if (!i_remote_on) off_cnt <= 16'h0000;
    else if (off_cnt != 16'hFFFF) off_cnt <= off_cnt + 16'h0001;
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) ov_cnt <= 16'hFFFF;
    else if (i_overvoltage_protect) ov_cnt <= 16'h0000;
    else if (ov_cnt != 16'hFFFF) ov_cnt <= ov_cnt + 16'h0001;
  end
  sequence s_prog_rules;
    (i_prog_connected && i_prog_cv <= PROG_LIMIT_CV && $stable(i_prog_cv)) [*3];
  endsequence
  sequence s_mode_restart;
    o_latched_off && i_wr && i_addr == REG_OV_MODE && !i_wdata[0];
  endsequence
  AST_PROG_SEL: assert property (s_prog_rules |-> o_prog_active && o_setpoint_cv == i_prog_cv)
    else $error("program pin not governing setpoint");
  AST_PIN_OFF: assert property (!i_remote_on [*3] |-> !o_main_enable)
    else $error("output on while enable pin low");
  AST_OC_OFF: assert property (i_overcurrent_protect [*3] |-> !o_main_enable)
    else $error("output on during overcurrent");
  AST_FAULT: assert property ((i_overvoltage_protect || i_overcurrent_protect || i_overtemp || i_no_output) [*3]
    |-> !o_fault_n)
    else $error("fault output idle during fault");
  AST_LATCH_OFF: assert property (o_latched_off |-> !o_main_enable)
    else $error("output on while latched off");
  AST_MIN_OFF: assert property ($rose(o_main_enable) |-> off_cnt >= OFF_MIN)
    else $error("restart after short off interval");
  AST_OV_DELAY: assert property ($rose(o_main_enable) |-> ov_cnt >= OV_MIN)
    else $error("overvoltage restart too early");
  AST_MODE_REL: assert property (s_mode_restart |-> ##[1:3] !o_latched_off)
    else $error("mode change did not release latch");
endmodule
bind frs_supervisor frs_supervisor_chk #(.TICK_CYCLES_P(TICK_CYCLES_P), .RESTART_TICKS(RESTART_TICKS),
  .MIN_OFF_T(MIN_OFF_T)) u_chk (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_prog_cv, .i_prog_connected,
  .i_remote_on, .i_overvoltage_protect, .i_overcurrent_protect, .i_overtemp, .i_no_output, .o_main_enable,
  .o_setpoint_cv, .o_prog_active, .o_fault_n, .o_latched_off);

// [tb/tb_fault_restart_supervisor.sv]
`timescale 1ns/1ps
module tb_fault_restart_supervisor;
  import frs_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_prog_connected = 1'b0;
  logic [11:0] i_prog_cv = 12'h000;
  logic i_remote_on = 1'b1;
  logic i_present_n = 1'b0;
  logic i_ac_ok = 1'b1;
  logic i_overcurrent_protect = 1'b0;
  logic i_overtemp = 1'b0;
  logic i_no_output = 1'b0;
  logic ov_fail = 1'b0;
  logic ov;
  logic [15:0] o_rdata;
  logic [11:0] o_setpoint_cv;
  logic o_main_enable;
  logic o_prog_active;
  logic o_fault_n;
  logic o_latched_off;
  int n_fail = 0;
  int checked = 0;
  int k;
  always #20 i_clock = ~i_clock;
  frs_stage_model stage (.i_clock(i_clock), .i_rst(i_rst), .i_main_enable(o_main_enable), .i_ov_fail(ov_fail),
    .o_overvoltage_protect(ov));
  frs_supervisor #(.TICK_CYCLES_P(10), .RESTART_TICKS(5), .MIN_OFF_T(8), .WINDOW_T(40)) dut (.i_clock(i_clock),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_prog_connected(i_prog_connected), .i_prog_cv(i_prog_cv), .i_remote_on(i_remote_on),
    .i_present_n(i_present_n), .i_ac_ok(i_ac_ok), .i_overvoltage_protect(ov),
    .i_overcurrent_protect(i_overcurrent_protect), .i_overtemp(i_overtemp), .i_no_output(i_no_output),
    .o_main_enable(o_main_enable), .o_setpoint_cv(o_setpoint_cv), .o_prog_active(o_prog_active),
    .o_fault_n(o_fault_n), .o_latched_off(o_latched_off));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata, e);
  endtask
  // main output must reach w no sooner than lo and before hi cycles
  task automatic span(input logic w, input int lo, input int hi);
    int i;
    for (i = 0; i < hi; i++) begin
      @(negedge i_clock);
      if (o_main_enable === w) break;
    end
    chk({15'h0, i >= lo && i < hi}, 16'h0001);
  endtask
  task automatic latch();
    int i;
    @(posedge i_clock);
    ov_fail <= 1'b1;
    for (i = 0; i < 600; i++) begin
      @(negedge i_clock);
      if (o_latched_off === 1'b1) break;
    end
    ov_fail <= 1'b0;
    chk({15'h0, o_latched_off}, 16'h0001);
    rd(REG_ALARM, 16'h0002);
    // let the restart delay run out so a release is not mixed up with it
    repeat (60) @(posedge i_clock);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    span(1'b1, 0, 6);
    rd(REG_OPERATION, OPERATION_RST);
    rd(REG_VOUT_CMD, VOUT_CMD_RST);
    rd(REG_OV_MODE, 16'h0001);
    rd(4'hF, 16'h0000);
    $display("reset value test done");
    wr(REG_VOUT_CMD, 16'h0400);
    for (k = 0; k < 3; k++) begin
      @(posedge i_clock);
      i_prog_connected <= (k != 2);
      i_prog_cv <= (k == 0) ? PROG_LIMIT_CV : (k == 1) ? PROG_LIMIT_CV + 12'h001 : 12'h000;
      repeat (4) @(negedge i_clock);
      chk({4'h0, o_setpoint_cv}, (k == 0) ? 16'h012C : 16'h0400);
      chk({15'h0, o_prog_active}, {15'h0, k == 0});
      rd(REG_SETPOINT, (k == 0) ? 16'h012C : 16'h0400);
    end
    $display("setpoint source test done");
    for (k = 0; k < 2; k++) begin
      @(posedge i_clock);
      {i_no_output, i_overtemp, i_overcurrent_protect} <= k ? 3'b010 : 3'b101;
      span(1'b0, 0, 4);
      chk({15'h0, o_fault_n}, 16'h0000);
      rd(REG_ALARM, k ? 16'h0001 : 16'h0014);
      @(posedge i_clock);
      {i_no_output, i_overtemp, i_overcurrent_protect} <= 3'b000;
      span(1'b1, 0, 4);
      rd(REG_ALARM, 16'h0000);
    end
    $display("auto restart test done");
    // one trip opens the window, which then lapses with no further trip
    @(posedge i_clock);
    ov_fail <= 1'b1;
    span(1'b0, 0, 10);
    @(posedge i_clock);
    ov_fail <= 1'b0;
    span(1'b1, 40, 60);
    rd(REG_STATUS, 16'h0028);
    repeat (420) @(posedge i_clock);
    rd(REG_STATUS, 16'h0000);
    $display("window lapse test done");
    for (k = 0; k < 4; k++) begin
      latch();
      if (k == 1) begin
        wr(REG_OPERATION, 16'h0000);
        repeat (800) @(posedge i_clock);
        wr(REG_OPERATION, 16'h0001);
      end else begin
        @(posedge i_clock);
        i_remote_on <= (k != 0);
        i_present_n <= (k == 2);
        i_ac_ok <= (k != 3);
        // a short pin pulse first, then the suggested long off time
        repeat ((k == 0) ? 3 : 800) @(posedge i_clock);
        i_remote_on <= 1'b1;
        i_present_n <= 1'b0;
        i_ac_ok <= 1'b1;
      end
      span(1'b1, 70, 100);
      rd(REG_ALARM, 16'h0000);
      $display("latch release path %0d done", k);
    end
    latch();
    wr(REG_OV_MODE, 16'h0000);
    span(1'b1, 0, 10);
    chk({15'h0, o_latched_off}, 16'h0000);
    // in auto-restart mode repeated trips keep restarting and never latch
    @(posedge i_clock);
    ov_fail <= 1'b1;
    repeat (250) @(negedge i_clock);
    chk({15'h0, o_latched_off}, 16'h0000);
    @(posedge i_clock);
    ov_fail <= 1'b0;
    span(1'b1, 0, 60);
    wr(REG_OV_MODE, 16'h0001);
    $display("mode release test done");
    stop_test();
  end
  // all tests take a few thousand cycles; 20000 means a hang
  initial begin
    #800000;
    n_fail++;
    stop_test();
  end
endmodule
